// ---- verilog/touch_ctrl_pkg.sv ----
package touch_ctrl_pkg;

  // Register indices on the byte-wide register port
  localparam logic [9:0] OFFS_OP = 10'h000;
  localparam logic [9:0] OFFS_TRK = 10'h001;
  localparam logic [9:0] ADDR_MAX = 10'h3ff;

  // Reset values
  localparam logic [15:0] OP_RESET = 16'h0000;
  localparam logic [15:0] TRK_RESET = 16'h0000;

  // Field positions in operating_control
  localparam int POS_MODE = 0;
  localparam int POS_SLEEP = 2;
  localparam int POS_STAGES = 4;
  localparam int POS_DECIM = 8;
  localparam int POS_SOFT_RESET = 10;
  localparam int POS_IRQ_LEVEL = 11;
  localparam int POS_DRIVE_A = 12;
  localparam int POS_DRIVE_B = 13;
  localparam int POS_TRIM = 14;
  // Field positions in stage_tracking_enables
  localparam int POS_TRACK = 0;
  localparam int POS_ACTIVE_SKIP = 12;
  localparam int POS_IDLE_SKIP = 14;

  localparam logic [3:0] STAGE_LAST_MAX = 4'hb;
  localparam int STAGE_COUNT = 12;

  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam logic [9:0] FP_PERIOD_MS = 10'h024;
  localparam logic [9:0] LP_DELAY_0_MS = 10'h0c8;
  localparam logic [9:0] LP_DELAY_1_MS = 10'h190;
  localparam logic [9:0] LP_DELAY_2_MS = 10'h258;
  localparam logic [9:0] LP_DELAY_3_MS = 10'h320;
  localparam logic [8:0] DECIM_SLOW = 9'h100;
  localparam logic [8:0] DECIM_FAST = 9'h080;
  localparam logic [5:0] ACTIVE_SKIP_BASE = 6'h04;

  typedef enum logic [1:0] {
    MODE_FULL = 2'b00,
    MODE_OFF_A = 2'b01,
    MODE_LOW = 2'b10,
    MODE_OFF_B = 2'b11
  } power_mode_t;

  typedef enum logic [1:0] {
    DECIM_256 = 2'b00,
    DECIM_128 = 2'b01,
    DECIM_BAD_A = 2'b10,
    DECIM_BAD_B = 2'b11
  } decim_t;

  typedef struct packed {
    logic [1:0] converter_current_trim;
    logic drive_out_b_disable;
    logic drive_out_a_disable;
    logic irq_level_select;
    logic soft_reset_trigger;
    decim_t decimation;
    logic [3:0] stage_last;
    logic [1:0] sleep_interval_select;
    power_mode_t power_mode;
  } op_ctrl_t;

  typedef struct packed {
    logic [1:0] idle_sample_skip;
    logic [1:0] active_sample_skip;
    logic [11:0] stage_track_enable;
  } tracking_t;

endpackage

// ---- verilog/ms_tick_gen.sv ----
`timescale 1ns/10ps
module ms_tick_gen
  import touch_ctrl_pkg::*;
#(
  parameter int TICK_CYCLES = MS_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // One-cycle enable each period
  output logic tick
);

  typedef struct packed {
    logic [31:0] count;
    logic tick;
  } tick_state_t;

  tick_state_t state;
  tick_state_t next_state;

  always_comb begin
    next_state = state;
    next_state.tick = 1'b0;
    if (state.count == 32'(TICK_CYCLES - 1)) begin
      next_state.count = 32'h0;
      next_state.tick = 1'b1;
    end else begin
      next_state.count = state.count + 32'h1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign tick = state.tick;

  a_tick_spacing: assert property (
    @(posedge clock) disable iff (!resetn)
    tick |-> state.count == 32'h0)
    else $error("tick out of phase with divider");

endmodule

// ---- verilog/conversion_sequencer.sv ----
`timescale 1ns/10ps
module conversion_sequencer
  import touch_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Control
  input wire logic start,
  input wire logic [3:0] stage_last,
  input wire logic [17:0] stage_cycles,
  // Status
  output logic busy,
  output logic [3:0] stage,
  output logic done
);

  typedef enum logic {
    SEQ_IDLE = 1'b0,
    SEQ_RUN = 1'b1
  } seq_state_t;

  typedef struct packed {
    seq_state_t mode;
    logic [3:0] stage;
    logic [3:0] last;
    logic [17:0] count;
    logic done;
  } seq_reg_t;

  seq_reg_t state;
  seq_reg_t next_state;

  always_comb begin
    next_state = state;
    next_state.done = 1'b0;
    unique case (state.mode)
      SEQ_IDLE: begin
        if (start) begin
          next_state.mode = SEQ_RUN;
          next_state.stage = 4'h0;
          // Codes above twelve stages are clamped
          next_state.last = (stage_last > STAGE_LAST_MAX) ?
            STAGE_LAST_MAX : stage_last;
          next_state.count = stage_cycles;
        end
      end
      SEQ_RUN: begin
        if (state.count > 18'h1) begin
          next_state.count = state.count - 18'h1;
        end else if (state.stage == state.last) begin
          next_state.mode = SEQ_IDLE;
          next_state.done = 1'b1;
        end else begin
          next_state.stage = state.stage + 4'h1;
          next_state.count = stage_cycles;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign busy = (state.mode == SEQ_RUN);
  assign stage = state.stage;
  assign done = state.done;

  a_stage_total: assert property (
    @(posedge clock) disable iff (!resetn)
    done |-> stage == state.last && state.last <= STAGE_LAST_MAX)
    else $error("sequence ended on wrong stage");

endmodule

// ---- verilog/touch_converter_power_sequence_ctrl.sv ----
// Functional notes
// - Mode 00 starts a conversion sequence 36 ms after the previous one ends.
// - Modes 01 and 11 shut down; no conversions start.
// - Mode 10 is low power; sequences start after a timed wait.
// - Low power wait is 200, 400, 600 or 800 ms by select code.
// - Stage field gives N+1 stages; host keeps it at most 1011.
// - Decimation 00 is by 256, 01 by 128; host avoids 10, 11.
// - Writing one to bit 10 restores defaults; bit never reads one.
// - Bit 12 zero enables first excitation output.
// - Bit 13 zero enables second excitation output.
// - Bits 15:14 set converter bias trim.
// - Tracking bits 0..11 enable calibration of matching stage.
// - Full power skip codes give 3, 7, 15 or 31 samples.
// - Low power skip codes give 0, 1, 2 or 3 samples.
// - Registers are 16 bits; written bytes pair high then low.
// - Readback gives high byte, then low, then pointer advances.
`timescale 1ns/10ps
module touch_converter_power_sequence_ctrl
  import touch_ctrl_pkg::*;
#(
  parameter int MS_TICK_CYCLES = MS_CYCLES,
  parameter int SAMPLE_CYCLES = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Byte-wide register port
  input wire logic addr_load,
  input wire logic [9:0] addr_value,
  input wire logic wr_strobe,
  input wire logic [7:0] wr_byte,
  input wire logic rd_strobe,
  output logic [7:0] rd_byte,
  output logic rd_valid,
  // Sequencer status
  output logic converting,
  output logic [3:0] stage_index,
  output logic sequence_done,
  output logic [1:0] active_mode,
  // Converter controls
  output logic stage_track_now,
  output logic [4:0] sample_skip,
  output logic decimate_by_128,
  output logic drive_out_a_enable,
  output logic drive_out_b_enable,
  output logic [1:0] converter_current_trim,
  output logic irq_level_select
);

  typedef struct packed {
    op_ctrl_t op;
    tracking_t trk;
    logic [9:0] ptr;
    logic [7:0] hi_byte;
    logic wr_phase;
    logic rd_phase;
    logic [15:0] rd_word;
    logic [7:0] rd_byte;
    logic rd_valid;
    power_mode_t mode;
    logic [9:0] wait_ms;
    logic seq_start;
  } top_state_t;

  top_state_t state;
  top_state_t next_state;
  logic ms_tick;
  logic seq_busy;
  logic seq_done;
  logic [3:0] seq_stage;
  logic [17:0] stage_cycles;
  logic wr_commit;

  ////////////////////////////////////////////////////////////////////////

  function automatic logic [15:0] read_reg(input logic [9:0] addr,
                                           input op_ctrl_t op,
                                           input tracking_t trk);
    if (addr == OFFS_OP) begin
      read_reg = op;
    end else if (addr == OFFS_TRK) begin
      read_reg = trk;
    end else begin
      read_reg = 16'h0000;
    end
  endfunction

  // Pointer holds at the top so late bytes fall on nothing
  function automatic logic [9:0] ptr_step(input logic [9:0] ptr);
    ptr_step = (ptr == ADDR_MAX) ? ptr : ptr + 10'h001;
  endfunction

  function automatic logic [9:0] wait_target(input power_mode_t mode,
                                             input logic [1:0] sel);
    if (mode == MODE_FULL) begin
      wait_target = FP_PERIOD_MS;
    end else begin
      unique case (sel)
        2'b00: wait_target = LP_DELAY_0_MS;
        2'b01: wait_target = LP_DELAY_1_MS;
        2'b10: wait_target = LP_DELAY_2_MS;
        2'b11: wait_target = LP_DELAY_3_MS;
      endcase
    end
  endfunction

  function automatic logic [4:0] skip_count(input power_mode_t mode,
                                            input tracking_t trk);
    logic [5:0] full;
    full = (ACTIVE_SKIP_BASE << trk.active_sample_skip) - 6'h01;
    if (mode == MODE_LOW) begin
      skip_count = {3'h0, trk.idle_sample_skip};
    end else begin
      skip_count = full[4:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////

  assign wr_commit = wr_strobe && !addr_load && state.wr_phase;

  always_comb begin
    logic [15:0] word;
    word = {state.hi_byte, wr_byte};
    next_state = state;
    next_state.rd_valid = 1'b0;
    next_state.seq_start = 1'b0;

    if (addr_load) begin
      next_state.ptr = addr_value;
      next_state.wr_phase = 1'b0;
      next_state.rd_phase = 1'b0;
    end else if (wr_strobe) begin
      if (!state.wr_phase) begin
        next_state.hi_byte = wr_byte;
        next_state.wr_phase = 1'b1;
      end else begin
        next_state.wr_phase = 1'b0;
        next_state.ptr = ptr_step(state.ptr);
        if (state.ptr == OFFS_OP) begin
          if (word[POS_SOFT_RESET]) begin
            // Self-clearing: the trigger is never stored
            next_state.op = OP_RESET;
            next_state.trk = TRK_RESET;
          end else begin
            next_state.op = word;
          end
        end else if (state.ptr == OFFS_TRK) begin
          next_state.trk = word;
        end
      end
    end else if (rd_strobe) begin
      next_state.rd_valid = 1'b1;
      if (!state.rd_phase) begin
        next_state.rd_word = read_reg(state.ptr, state.op, state.trk);
        next_state.rd_byte = next_state.rd_word[15:8];
        next_state.rd_phase = 1'b1;
      end else begin
        next_state.rd_byte = state.rd_word[7:0];
        next_state.rd_phase = 1'b0;
        next_state.ptr = ptr_step(state.ptr);
      end
    end

    // Mode is taken over only while no sequence runs
    if (!seq_busy && !state.seq_start) begin
      if (state.mode != state.op.power_mode) begin
        next_state.mode = state.op.power_mode;
        next_state.wait_ms = 10'h000;
      end else if (state.mode == MODE_FULL || state.mode == MODE_LOW) begin
        if (ms_tick) begin
          if (state.wait_ms == wait_target(state.mode,
              state.op.sleep_interval_select) - 10'h001) begin
            next_state.wait_ms = 10'h000;
            next_state.seq_start = 1'b1;
          end else begin
            next_state.wait_ms = state.wait_ms + 10'h001;
          end
        end
      end else begin
        next_state.wait_ms = 10'h000;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////

  // Codes 10 and 11 are forbidden; they fall back to the slow rate
  assign stage_cycles = 18'((state.op.decimation == DECIM_128 ?
    DECIM_FAST : DECIM_SLOW) * SAMPLE_CYCLES);

  ms_tick_gen #(
    .TICK_CYCLES(MS_TICK_CYCLES)
  ) u_ms_tick (
    .clock(clock),
    .resetn(resetn),
    .tick(ms_tick)
  );

  conversion_sequencer u_sequencer (
    .clock(clock),
    .resetn(resetn),
    .start(state.seq_start),
    .stage_last(state.op.stage_last),
    .stage_cycles(stage_cycles),
    .busy(seq_busy),
    .stage(seq_stage),
    .done(seq_done)
  );

  assign rd_byte = state.rd_byte;
  assign rd_valid = state.rd_valid;
  assign converting = seq_busy;
  assign stage_index = seq_stage;
  assign sequence_done = seq_done;
  assign active_mode = state.mode;
  assign stage_track_now = seq_busy &&
    state.trk.stage_track_enable[seq_stage];
  assign sample_skip = skip_count(state.mode, state.trk);
  assign decimate_by_128 = (state.op.decimation == DECIM_128);
  assign drive_out_a_enable = !state.op.drive_out_a_disable;
  assign drive_out_b_enable = !state.op.drive_out_b_disable;
  assign converter_current_trim = state.op.converter_current_trim;
  assign irq_level_select = state.op.irq_level_select;

  ////////////////////////////////////////////////////////////////////////

  a_off_no_start: assert property (
    @(posedge clock) disable iff (!resetn)
    (state.mode == MODE_OFF_A || state.mode == MODE_OFF_B) &&
    state.op.power_mode == state.mode |=> !state.seq_start)
    else $error("conversion started while shut down");

  a_full_period: assert property (
    @(posedge clock) disable iff (!resetn)
    !state.seq_start ##1 state.seq_start && state.mode == MODE_FULL
    |-> $past(state.wait_ms) == FP_PERIOD_MS - 10'h001)
    else $error("full power period wrong");

  a_low_interval: assert property (
    @(posedge clock) disable iff (!resetn)
    state.seq_start && state.mode == MODE_LOW |->
    $past(state.wait_ms) == wait_target(MODE_LOW,
    $past(state.op.sleep_interval_select)) - 10'h001)
    else $error("low power interval wrong");

  a_start_runs: assert property (
    @(posedge clock) disable iff (!resetn)
    state.seq_start |-> !seq_busy ##1 seq_busy)
    else $error("start did not begin a sequence");

  a_soft_reset_all: assert property (
    @(posedge clock) disable iff (!resetn)
    wr_commit && state.ptr == OFFS_OP && state.hi_byte[2] |=>
    state.op == OP_RESET && state.trk == TRK_RESET)
    else $error("soft reset did not restore defaults");

  a_trigger_clear: assert property (
    @(posedge clock) disable iff (!resetn)
    wr_commit && state.ptr == OFFS_OP |=> !state.op.soft_reset_trigger)
    else $error("soft reset bit was stored");

  a_drive_a_write: assert property (
    @(posedge clock) disable iff (!resetn)
    wr_commit && state.ptr == OFFS_OP && !state.hi_byte[2] |=>
    drive_out_a_enable == !$past(state.hi_byte[4]))
    else $error("first excitation enable wrong");

  a_drive_b_write: assert property (
    @(posedge clock) disable iff (!resetn)
    wr_commit && state.ptr == OFFS_OP && !state.hi_byte[2] |=>
    drive_out_b_enable == !$past(state.hi_byte[5]))
    else $error("second excitation enable wrong");

  a_track_write: assert property (
    @(posedge clock) disable iff (!resetn)
    wr_commit && state.ptr == OFFS_TRK |=>
    state.trk == $past({state.hi_byte, wr_byte}))
    else $error("tracking word not stored high byte first");

  a_read_order: assert property (
    @(posedge clock) disable iff (!resetn)
    rd_strobe && !addr_load && !wr_strobe && !state.rd_phase &&
    state.ptr == OFFS_OP ##1 rd_strobe && !addr_load && !wr_strobe
    |=> rd_valid && rd_byte == $past(state.op[7:0], 2) &&
    state.ptr == OFFS_TRK)
    else $error("readback order or pointer wrong");

  a_read_high: assert property (
    @(posedge clock) disable iff (!resetn)
    rd_strobe && !addr_load && !wr_strobe && !state.rd_phase &&
    state.ptr == OFFS_TRK |=>
    rd_valid && rd_byte == $past(state.trk[15:8]))
    else $error("readback high byte wrong");

  a_read_answer: assert property (
    @(posedge clock) disable iff (!resetn)
    rd_valid |-> $past(rd_strobe && !addr_load && !wr_strobe))
    else $error("read answer without request");

  a_mode_held: assert property (
    @(posedge clock) disable iff (!resetn)
    seq_busy && $past(seq_busy) |-> $stable(state.mode))
    else $error("mode changed inside a sequence");

endmodule

// ---- tb/touch_host_model.sv ----
`timescale 1ns/10ps
module touch_host_model (
  // Clock
  input wire logic clock,
  // Byte-wide register port
  output logic addr_load,
  output logic [9:0] addr_value,
  output logic wr_strobe,
  output logic [7:0] wr_byte,
  output logic rd_strobe,
  input wire logic [7:0] rd_byte,
  input wire logic rd_valid
);
  initial begin
    addr_load = 1'b0;
    addr_value = 10'h155;
    wr_strobe = 1'b0;
    wr_byte = 8'h5a;
    rd_strobe = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic point(input logic [9:0] a);
    @(posedge clock);
    addr_load <= 1'b1;
    addr_value <= a;
    @(posedge clock);
    addr_load <= 1'b0;
    // Released value must not look like the last one
    addr_value <= ~a;
  endtask

  // Only whole pairs, high byte first
  task automatic wr(input logic [9:0] a, input logic [15:0] q[$]);
    point(a);
    wr_strobe <= 1'b1;
    foreach (q[i]) begin
      wr_byte <= q[i][15:8];
      @(posedge clock);
      wr_byte <= q[i][7:0];
      @(posedge clock);
    end
    wr_strobe <= 1'b0;
    wr_byte <= ~q[q.size()-1][7:0];
  endtask

  // Strobe held across the burst; each byte lands one cycle later
  task automatic rd(input logic [9:0] a, input int n,
                    output logic [15:0] q[$]);
    logic [7:0] hi;
    q = {};
    point(a);
    rd_strobe <= 1'b1;
    @(posedge clock);
    for (int k = 0; k < 2 * n; k++) begin
      if (k == 2 * n - 1) rd_strobe <= 1'b0;
      @(posedge clock);
      if (k[0]) q.push_back({hi, rd_valid ? rd_byte : 8'hxx});
      else hi = rd_valid ? rd_byte : 8'hxx;
    end
  endtask
endmodule

// ---- tb/test_touch_converter_power_sequence_ctrl.sv ----
`timescale 1ns/10ps
module test_touch_converter_power_sequence_ctrl;
  import touch_ctrl_pkg::*;
  localparam int TK = 10;
  logic clock, resetn, addr_load, wr_strobe, rd_strobe, rd_valid;
  logic [9:0] addr_value;
  logic [7:0] wr_byte, rd_byte;
  logic converting, sequence_done, stage_track_now, decimate_by_128;
  logic drive_out_a_enable, drive_out_b_enable, irq_level_select;
  logic [3:0] stage_index;
  logic [1:0] active_mode, converter_current_trim;
  logic [4:0] sample_skip;
  logic [15:0] op, tr;
  logic [15:0] wq[$], rq[$];
  int num_errors, comparisons, n;
  bit mon;

  touch_converter_power_sequence_ctrl #(
    .MS_TICK_CYCLES(TK), .SAMPLE_CYCLES(1)
  ) i_dut (
    .clock, .resetn, .addr_load, .addr_value, .wr_strobe, .wr_byte,
    .rd_strobe, .rd_byte, .rd_valid, .converting, .stage_index,
    .sequence_done, .active_mode, .stage_track_now, .sample_skip,
    .decimate_by_128, .drive_out_a_enable, .drive_out_b_enable,
    .converter_current_trim, .irq_level_select
  );

  touch_host_model i_host (
    .clock, .addr_load, .addr_value, .wr_strobe, .wr_byte, .rd_strobe,
    .rd_byte, .rd_valid
  );

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, s);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, s);
    end
  endtask

  task automatic conclude();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic put(input logic [9:0] a, input logic [15:0] v);
    wq = {v};
    i_host.wr(a, wq);
  endtask

  task automatic idle();
    n = 0;
    while (converting && n < 4000) begin
      @(posedge clock);
      n++;
    end
    chk("idle_limit", 1, n < 4000);
    repeat (2) @(posedge clock);
  endtask

  task automatic outs(input logic [15:0] o, t);
    int skip;
    skip = o[1:0] == 2'b10 ? t[15:14] : (4 << t[13:12]) - 1;
    chk("mode", o[1:0], active_mode);
    chk("skip", skip, sample_skip);
    chk("decim", o[9:8] == 2'b01, decimate_by_128);
    chk("drive_a", !o[12], drive_out_a_enable);
    chk("drive_b", !o[13], drive_out_b_enable);
    chk("trim", o[15:14], converter_current_trim);
    chk("irq", o[11], irq_level_select);
  endtask

  // Idle gap before a sequence, its busy length and last stage
  task automatic meas(input int gap, len, last);
    int g, l, top;
    g = 0;
    l = 0;
    top = 0;
    while (!converting && g < 20000) begin
      @(posedge clock);
      g++;
    end
    chk("start", 1, g < 20000);
    while (converting && l < 5000) begin
      if (stage_index > top) top = stage_index;
      @(posedge clock);
      l++;
    end
    // Done pulse stands in the first cycle after converting falls
    chk("done", 1, sequence_done);
    if (gap > 0) begin
      chk("gap", 1, g >= (gap - 1) * TK && g <= (gap + 2) * TK);
    end
    chk("length", 1, l >= len - 2 && l <= len + 2);
    chk("last", last, top);
  endtask

  task automatic run(input logic [15:0] o, input int gap, len, last);
    put(10'h000, o);
    meas(0, len, last);
    meas(gap, len, last);
    outs(o, tr);
  endtask

  // Tracking strobe follows the enable of the running stage
  always @(negedge clock) begin
    if (mon) begin
      chk("track", converting & tr[stage_index], stage_track_now);
    end
  end

  initial begin
    repeat (90000) @(posedge clock);
    num_errors++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(92534));
    num_errors = 0;
    comparisons = 0;
    mon = 0;
    tr = 16'h0000;
    resetn = 1'b0;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    i_host.rd(10'h000, 2, rq);
    chk("op_reset", 16'h0000, rq[0]);
    chk("trk_reset", 16'h0000, rq[1]);
    outs(16'h0000, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      op = 16'($urandom);
      op[1:0] = i[0] ? 2'b11 : 2'b01;
      op[7:4] = 4'($urandom_range(11));
      op[9:8] = {1'b0, 1'($urandom)};
      op[10] = 1'b0;
      tr = 16'($urandom);
      // Third word falls on an unmapped index
      wq = {op, tr, 16'hffff};
      i_host.wr(10'h000, wq);
      idle();
      i_host.rd(10'h000, 3, rq);
      chk("op", op, rq[0]);
      chk("trk", tr, rq[1]);
      chk("unmapped", 16'h0000, rq[2]);
      outs(op, tr);
      n = 0;
      repeat (400) begin
        @(posedge clock);
        n += converting;
      end
      chk("shutdown", 0, n);
    end
    put(10'h000, 16'h0400 | 16'($urandom));
    i_host.rd(10'h000, 2, rq);
    chk("srst_op", 16'h0000, rq[0]);
    chk("srst_trk", 16'h0000, rq[1]);
    tr = 16'($urandom);
    put(10'h001, tr);
    mon = 1;
    run({6'h00, 2'b01, 4'hb, 2'b00, 2'b00}, 36, 1536, 11);
    run({6'h00, 2'b00, 4'h0, 2'b00, 2'b00}, 36, 256, 0);
    for (int s = 0; s < 4; s++) begin
      run({6'h00, 2'b01, 4'h1, 2'(s), 2'b10}, 200 + 200 * s, 256, 1);
    end
    put(10'h000, 16'h00b0);
    n = 0;
    while (!converting && n < 1000) begin
      @(posedge clock);
      n++;
    end
    chk("full_start", 1, converting);
    put(10'h000, 16'h0001);
    // Let the new mode reach a point where it could be applied
    repeat (2) @(posedge clock);
    chk("mode_hold", 2'b00, active_mode);
    idle();
    chk("mode_apply", 2'b01, active_mode);
    conclude();
  end
endmodule
